//--- rtl/lcp_defines.svh
/*
  Constants for the parallel host port of the character display controller.
  Assumes inclusion by the package and the port module only.
*/
// Behaviour
// - select low: write command, read busy/address
// - select high: data register both directions
// - direction line high reads, low writes
// - strobe high starts, falling edge transfers
// - four-bit mode uses upper four lines
// - drive data lines only during reads
// - busy flag on top data line
// - busy set refuses new instructions
// - two eight-bit host registers
// - command register never readable
// - data read stages RAM byte first
// - frame rate is clock over 2304
// - sub-address pin picks one of two
// - five bias levels 1:16, six 1:32
// - reset initialises all internal state except RAM contents
// - address counter on low seven lines
// - address steps after each RAM access
`ifndef LCP_DEFINES_SVH
`define LCP_DEFINES_SVH
`define LCP_DATA_W       8
`define LCP_ADDR_W       7
`define LCP_BUSY_BIT     7
`define LCP_FRAME_DIV    2304
`define LCP_EXEC_CYCLES  16'h0100
`define LCP_CLEAR_CYCLES 16'h2000
`define LCP_RAM_DEPTH    128
`define LCP_GLYPH_DEPTH  64
`define LCP_BIAS_MUX16   3'h5
`define LCP_BIAS_MUX32   3'h6
`define LCP_SUBADDR_BASE 7'h3a
`endif

//--- rtl/lcp_pkg.sv
/*
  Types for the parallel host port.
  Assumes lcp_defines.svh is on the include path.
*/
`include "lcp_defines.svh"
package lcp_pkg;
  typedef struct packed {
    logic regSel;   // 1 data, 0 command/status
    logic readNotWr;// 1 read
    logic strobe;   // bus strobe
  } lcp_ctl_s;

  typedef struct packed {
    logic [`LCP_DATA_W-1:0] out; // driven value
    logic                   oeB; // low while driving
  } lcp_drv_s;

  typedef enum logic [1:0] {
    LCP_IDLE = 2'b00,
    LCP_EXEC = 2'b01
  } lcp_state_e;
endpackage : lcp_pkg

//--- rtl/lcp_host_port.sv
/*
  Parallel host port: strobe sampling, command/data registers, busy flag,
  address counter, RAM staging and frame divider.
  Assumes host pins synchronous to sys_clk; strobe pulses span several cycles.
*/
`timescale 1ns/10ps
`include "lcp_defines.svh"
module lcp_host_port
  import lcp_pkg::*;
#(
  parameter int FRAME_DIV   = `LCP_FRAME_DIV,
  parameter int CLEAR_CYCLES = `LCP_CLEAR_CYCLES
) (
  input  wire logic                    sys_clk,     // 200 MHz clock
  input  wire logic                    rst_b,       // sync reset, active low
  input  wire lcp_ctl_s                ctl,         // select, direction, strobe
  input  wire logic [`LCP_DATA_W-1:0]  dataIn,      // data_lines input
  output lcp_drv_s                     dataDrv,     // data_lines out and enable
  input  wire logic                    nibbleMode,  // 1 selects 4-bit bus
  input  wire logic                    subaddrPin,  // sub-address strap
  input  wire logic                    mux32,       // 1 selects 1:32 drive
  output logic [`LCP_ADDR_W-1:0]       serialAddr,  // serial bus address
  output logic [2:0]                   biasLevels,  // bias level count
  output logic                         frameTick,   // one pulse per frame
  output logic [`LCP_DATA_W-1:0]       cmdCode,     // last accepted instruction
  output logic                         cmdValid     // pulse on accepted one
);
  logic [`LCP_DATA_W-1:0] textRam  [`LCP_RAM_DEPTH];
  logic [`LCP_DATA_W-1:0] glyphRam [`LCP_GLYPH_DEPTH];

  logic                   strobeQ, next_strobeQ;
  logic                   hiPhase, next_hiPhase;
  logic [3:0]             hiNib, next_hiNib;
  lcp_state_e             state, next_state;
  logic [15:0]            execCnt, next_execCnt;
  logic [`LCP_DATA_W-1:0] cmdReg, next_cmdReg;
  logic [`LCP_DATA_W-1:0] dataReg, next_dataReg;
  logic [`LCP_ADDR_W-1:0] addrCnt, next_addrCnt;
  logic                   glyphSel, next_glyphSel;
  logic                   incDir, next_incDir;
  logic                   next_cmdValid;
  logic [`LCP_DATA_W-1:0] next_cmdCode;
  logic [11:0]            frameCnt, next_frameCnt;
  logic                   next_frameTick;
  logic                   ramWr;
  logic [`LCP_DATA_W-1:0] ramWrData;
  logic [`LCP_DATA_W-1:0] ramRd;
  logic                   busy;
  logic                   fallEdge;
  logic                   byteDone;
  logic [`LCP_DATA_W-1:0] byteIn;
  logic [`LCP_DATA_W-1:0] rdByte;
  lcp_drv_s               next_dataDrv;
  logic                   cmdAccept;
  logic                   dataWrite;
  logic                   dataRead;

  function automatic logic [`LCP_ADDR_W-1:0] stepAddr(input logic [`LCP_ADDR_W-1:0] a, input logic up);
    stepAddr = up ? a + 7'h01 : a - 7'h01;
  endfunction : stepAddr

  // instruction class decoders
  function automatic logic isClear(input logic [`LCP_DATA_W-1:0] c);
    return c == 8'h01;
  endfunction : isClear

  function automatic logic isTextAddr(input logic [`LCP_DATA_W-1:0] c);
    return c[7];
  endfunction : isTextAddr

  function automatic logic isGlyphAddr(input logic [`LCP_DATA_W-1:0] c);
    return c[7:6] == 2'b01;
  endfunction : isGlyphAddr

  function automatic logic isEntryMode(input logic [`LCP_DATA_W-1:0] c);
    return c[7:2] == 6'h01;
  endfunction : isEntryMode

  function automatic logic isHome(input logic [`LCP_DATA_W-1:0] c);
    return (c[7:1] == 7'h01) || isClear(c);
  endfunction : isHome

  assign busy     = (state == LCP_EXEC);
  assign fallEdge = strobeQ & ~ctl.strobe;
  assign ramRd    = glyphSel ? glyphRam[addrCnt[5:0]] : textRam[addrCnt];

  // status read: busy on top line, counter below; command reg never read
  always_comb begin
    if (!ctl.regSel) begin
      rdByte = {busy, addrCnt};
    end else begin
      rdByte = dataReg;
    end
  end

  // strobe edge and nibble assembly
  always_comb begin
    next_strobeQ = ctl.strobe;
    next_hiPhase = hiPhase;
    next_hiNib   = hiNib;
    byteDone     = 1'b0;
    byteIn       = dataIn;
    if (fallEdge) begin
      if (nibbleMode) begin
        next_hiPhase = ~hiPhase;
        if (!hiPhase) begin
          next_hiNib = dataIn[7:4];
        end else begin
          byteDone = 1'b1;
          byteIn   = {hiNib, dataIn[7:4]};
        end
      end else begin
        byteDone = 1'b1;
      end
    end
    // leaving 4-bit mode realigns to the upper nibble
    if (!nibbleMode) begin
      next_hiPhase = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strobeQ <= 1'b0;
      hiPhase <= 1'b0;
      hiNib   <= 4'h0;
    end else begin
      strobeQ <= next_strobeQ;
      hiPhase <= next_hiPhase;
      hiNib   <= next_hiNib;
    end
  end

  // completed byte classified by select and direction
  assign cmdAccept = byteDone & ~ctl.readNotWr & ~ctl.regSel & ~busy;
  assign dataWrite = byteDone & ~ctl.readNotWr & ctl.regSel;
  assign dataRead  = byteDone & ctl.readNotWr & ctl.regSel;

  // instruction execution timer
  always_comb begin
    next_state   = state;
    next_execCnt = execCnt;
    if (busy) begin
      next_execCnt = execCnt - 16'h0001;
      if (execCnt <= 16'h0001) begin
        next_state = LCP_IDLE;
      end
    end
    // accept only happens when idle, so it never meets the countdown
    if (cmdAccept) begin
      next_state   = LCP_EXEC;
      next_execCnt = isClear(byteIn) ? CLEAR_CYCLES[15:0] : `LCP_EXEC_CYCLES;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state   <= LCP_IDLE;
      execCnt <= 16'h0000;
    end else begin
      state   <= next_state;
      execCnt <= next_execCnt;
    end
  end

  // host registers and address counter
  always_comb begin
    next_cmdReg   = cmdReg;
    next_dataReg  = dataReg;
    next_addrCnt  = addrCnt;
    next_glyphSel = glyphSel;
    next_incDir   = incDir;
    next_cmdValid = 1'b0;
    next_cmdCode  = cmdCode;
    ramWr         = 1'b0;
    ramWrData     = dataReg;
    if (cmdAccept) begin
      next_cmdReg   = byteIn;
      next_cmdValid = 1'b1;
      next_cmdCode  = byteIn;
      if (isTextAddr(byteIn)) begin
        next_addrCnt  = byteIn[6:0];
        next_glyphSel = 1'b0;
      end else if (isGlyphAddr(byteIn)) begin
        next_addrCnt  = {1'b0, byteIn[5:0]};
        next_glyphSel = 1'b1;
      end else if (isEntryMode(byteIn)) begin
        next_incDir = byteIn[1];
      end else if (isHome(byteIn)) begin
        next_addrCnt  = 7'h00;
        next_glyphSel = 1'b0;
        next_incDir   = 1'b1;
      end
    end
    // data traffic is taken even while an instruction runs
    if (dataWrite) begin
      next_dataReg = byteIn;
      ramWr        = 1'b1;
      ramWrData    = byteIn;
      next_addrCnt = stepAddr(addrCnt, incDir);
    end
    if (dataRead) begin
      next_dataReg = ramRd;
      next_addrCnt = stepAddr(addrCnt, incDir);
    end
  end

  // drive only while a read strobe is high
  always_comb begin
    next_dataDrv.oeB = ~(ctl.strobe & ctl.readNotWr);
    next_dataDrv.out = (nibbleMode && hiPhase) ? {rdByte[3:0], 4'h0} : rdByte;
  end

  // frame divider
  always_comb begin
    next_frameTick = 1'b0;
    next_frameCnt  = frameCnt + 12'h001;
    if (frameCnt == 12'(FRAME_DIV - 1)) begin
      next_frameCnt  = 12'h000;
      next_frameTick = 1'b1;
    end
  end

  assign biasLevels = mux32 ? `LCP_BIAS_MUX32 : `LCP_BIAS_MUX16;
  assign serialAddr = `LCP_SUBADDR_BASE | {6'h00, subaddrPin};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmdReg   <= 8'h00;
      dataReg  <= 8'h00;
      addrCnt  <= 7'h00;
      glyphSel <= 1'b0;
      incDir   <= 1'b1;
      cmdValid <= 1'b0;
      cmdCode  <= 8'h00;
    end else begin
      cmdReg   <= next_cmdReg;
      dataReg  <= next_dataReg;
      addrCnt  <= next_addrCnt;
      glyphSel <= next_glyphSel;
      incDir   <= next_incDir;
      cmdValid <= next_cmdValid;
      cmdCode  <= next_cmdCode;
    end
  end

  // line drive register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dataDrv <= '{out: 8'h00, oeB: 1'b1};
    end else begin
      dataDrv <= next_dataDrv;
    end
  end

  // frame divider register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      frameCnt  <= 12'h000;
      frameTick <= 1'b0;
    end else begin
      frameCnt  <= next_frameCnt;
      frameTick <= next_frameTick;
    end
  end

  // RAM contents are not reset
  always_ff @(posedge sys_clk) begin
    if (ramWr && glyphSel) begin
      glyphRam[addrCnt[5:0]] <= ramWrData;
    end
    if (ramWr && !glyphSel) begin
      textRam[addrCnt] <= ramWrData;
    end
  end
endmodule : lcp_host_port

//--- sim/lcp_host_port_assertions.sv
/* port checker for lcp_host_port.
   assumes the bind below and a sync active-low reset. */
`timescale 1ns/10ps
module lcp_host_port_assertions
  import lcp_pkg::*;
#(parameter int FRAME_DIV = 2304, parameter int CLEAR_CYCLES = 8192) (
  input wire logic       sys_clk,    // clock
  input wire logic       rst_b,      // reset
  input wire lcp_ctl_s   ctl,        // control
  input wire logic [7:0] dataIn,     // lines in
  input wire lcp_drv_s   dataDrv,    // lines out
  input wire logic       nibbleMode, // 4-bit
  input wire logic       mux32,      // 1:32
  input wire logic [2:0] biasLevels, // bias
  input wire logic       frameTick,  // frame
  input wire logic [7:0] cmdCode,    // command
  input wire logic       cmdValid    // accepted
);
  logic [15:0] gap;
  logic [15:0] fcnt;
  logic        seen;
  logic        lastClr;
  always_ff @(posedge sys_clk) begin
    lastClr <= !rst_b ? 1'b0 : cmdValid ? (cmdCode == 8'h01) : lastClr;
    gap  <= !rst_b ? 16'hffff : cmdValid ? 16'h0000 : gap + {15'h0, gap != 16'hffff};
    fcnt <= (!rst_b || frameTick) ? 16'h0000 : fcnt + 16'h0001;
    seen <= rst_b && (seen || frameTick);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_OE_DRIVE: assert property (ctl.strobe && ctl.readNotWr |=> !dataDrv.oeB)
    else $error("read not driven");
  AST_OE_CAUSE: assert property (!dataDrv.oeB |-> $past(ctl.strobe && ctl.readNotWr))
    else $error("lines driven outside read");
  AST_CMD_SRC: assert property (cmdValid |-> $past(!ctl.regSel && !ctl.readNotWr && !ctl.strobe))
    else $error("instruction without command write");
  AST_CMD_CODE: assert property (cmdValid && !nibbleMode |-> cmdCode == $past(dataIn))
    else $error("instruction code wrong");
  AST_CMD_GAP: assert property (cmdValid |-> gap >= (lastClr ? 16'(CLEAR_CYCLES) : 16'h0100))
    else $error("instruction taken while busy");
  AST_BUSY_BIT: assert property (!dataDrv.oeB && !ctl.regSel && !nibbleMode && !lastClr && gap < 16'h00fe |-> dataDrv.out[7])
    else $error("busy not shown");
  AST_BIAS: assert property (biasLevels == (mux32 ? 3'h6 : 3'h5))
    else $error("bias count wrong");
  AST_FRAME: assert property (frameTick && seen |-> fcnt == FRAME_DIV - 1)
    else $error("frame period wrong");
endmodule : lcp_host_port_assertions
bind lcp_host_port lcp_host_port_assertions #(.FRAME_DIV(FRAME_DIV), .CLEAR_CYCLES(CLEAR_CYCLES)) u_chk (.*);

//--- sim/lcp_host_model.sv
/* host microcontroller on the parallel port.
   assumes pull-ups on the data lines; tasks called from tb_top. */
`timescale 1ns/10ps
module lcp_host_model
  import lcp_pkg::*;
(
  input  wire logic     sys_clk,    // clock
  input  wire lcp_drv_s dataDrv,    // device drive
  input  wire logic     nibbleMode, // 4-bit bus
  output lcp_ctl_s      ctl,        // control lines
  output logic [7:0]    dataIn      // resolved lines
);
  logic       hostOn = 1'b0;
  logic [7:0] hostVal = 8'h00;
  initial ctl = '0;
  assign dataIn = !dataDrv.oeB ? dataDrv.out : hostOn ? (nibbleMode ? {hostVal[7:4], 4'hf} : hostVal) : 8'hff;
  task automatic cycle(input logic rs, input logic rnw, input logic [7:0] v, output logic [7:0] rd);
    @(posedge sys_clk);
    ctl     <= '{regSel: rs, readNotWr: rnw, strobe: 1'b1};
    hostOn  <= !rnw;
    hostVal <= v;
    repeat (3) @(posedge sys_clk);
    rd = dataDrv.out;
    ctl.strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    hostOn <= 1'b0;
  endtask : cycle
  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] v, output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (!nibbleMode) cycle(rs, rnw, v, rd);
    else begin
      cycle(rs, rnw, v, hi);
      cycle(rs, rnw, {v[3:0], 4'h0}, lo);
      rd = {hi[7:4], lo[7:4]};
    end
  endtask : xfer
endmodule : lcp_host_model

//--- sim/tb_top.sv
/* self-checking bench for lcp_host_port.
   host model drives the port; ram and address tracked here. */
`timescale 1ns/10ps
module tb_top
  import lcp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        nibbleMode = 1'b0;
  logic        subaddrPin = 1'b0;
  logic        mux32 = 1'b0;
  lcp_ctl_s    ctl;
  lcp_drv_s    dataDrv;
  logic [7:0]  dataIn, cmdCode, rd, b;
  logic [6:0]  serialAddr, a;
  logic [2:0]  biasLevels;
  logic        frameTick, cmdValid;
  logic [31:0] seed = 32'h84b8;
  int          failures = 0, checksDone = 0;
  int          tickGap = 0;
  logic        tickSeen = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rst_b && frameTick && tickSeen) chk("frame period", 8'h08, 8'(tickGap));
    tickGap  <= frameTick ? 1 : tickGap + 1;
    tickSeen <= rst_b && (tickSeen || frameTick);
  end
  lcp_host_port #(.FRAME_DIV(8), .CLEAR_CYCLES(16)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ctl(ctl),
    .dataIn(dataIn), .dataDrv(dataDrv), .nibbleMode(nibbleMode), .subaddrPin(subaddrPin), .mux32(mux32),
    .serialAddr(serialAddr), .biasLevels(biasLevels), .frameTick(frameTick), .cmdCode(cmdCode), .cmdValid(cmdValid));
  lcp_host_model u_host (.sys_clk(sys_clk), .dataDrv(dataDrv), .nibbleMode(nibbleMode), .ctl(ctl), .dataIn(dataIn));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (exp !== got) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic testDone;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : testDone
  task automatic waitIdle;
    int n = 0;
    do begin
      u_host.xfer(1'b0, 1'b1, 8'h00, rd);
      n++;
    end while (rd[7] !== 1'b0 && n < 100);
    if (rd[7] !== 1'b0) begin
      failures++;
      testDone();
    end
  endtask : waitIdle
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    u_host.xfer(1'b0, 1'b1, 8'h00, rd);
    chk("status after reset", 8'h00, rd);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = seed[6:0];
      b = seed[23:16];
      nibbleMode <= i[0];
      subaddrPin <= seed[9];
      mux32      <= seed[10];
      @(posedge sys_clk);
      u_host.xfer(1'b0, 1'b0, {1'b1, a}, rd);
      u_host.xfer(1'b0, 1'b0, {1'b1, ~a}, rd);
      u_host.xfer(1'b0, 1'b1, 8'h00, rd);
      chk("busy status", {1'b1, a}, rd);
      chk("instruction code", {1'b1, a}, cmdCode);
      waitIdle();
      u_host.xfer(1'b1, 1'b0, b, rd);
      u_host.xfer(1'b1, 1'b0, ~b, rd);
      u_host.xfer(1'b0, 1'b1, 8'h00, rd);
      chk("address step", {1'b0, a + 7'h02}, {1'b0, rd[6:0]});
      u_host.xfer(1'b0, 1'b0, {1'b1, a}, rd);
      waitIdle();
      u_host.xfer(1'b1, 1'b1, 8'h00, rd);
      u_host.xfer(1'b1, 1'b1, 8'h00, rd);
      chk("staged byte", b, rd);
      u_host.xfer(1'b1, 1'b1, 8'h00, rd);
      chk("next staged byte", ~b, rd);
      chk("line enable idle", 8'h01, {7'h0, dataDrv.oeB});
      chk("bias", {5'h0, mux32 ? 3'h6 : 3'h5}, {5'h0, biasLevels});
      chk("serial address", {1'b0, 7'h3a | {6'h0, subaddrPin}}, {1'b0, serialAddr});
      $display("test %0d done", i);
    end
    u_host.xfer(1'b0, 1'b0, 8'h04, rd);
    waitIdle();
    u_host.xfer(1'b1, 1'b0, b, rd);
    u_host.xfer(1'b0, 1'b1, 8'h00, rd);
    chk("address step down", {1'b0, a + 7'h02}, {1'b0, rd[6:0]});
    u_host.xfer(1'b0, 1'b0, 8'h01, rd);
    u_host.xfer(1'b0, 1'b1, 8'h00, rd);
    chk("clear status", 8'h80, rd);
    waitIdle();
    $display("test clear done");
    testDone();
  end
endmodule : tb_top
